/* File: angle_path_pkg.sv */
// package: constants and carriers for the angle signal path
`default_nettype none
package angle_path_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRE_OFFS = 8'h04;
  localparam logic [7:0] OFS_THRESH = 8'h08;
  localparam logic [7:0] OFS_GAIN = 8'h0C;
  localparam logic [7:0] OFS_ROLLOVER = 8'h10;
  localparam logic [7:0] OFS_POST_OFFS = 8'h14;
  localparam logic [7:0] OFS_HYST_A = 8'h18;
  localparam logic [7:0] OFS_HYST_B = 8'h1C;
  localparam logic [7:0] OFS_TC_A = 8'h20;
  localparam logic [7:0] OFS_TC_B = 8'h24;
  localparam logic [7:0] OFS_READBACK_A = 8'h28;
  localparam logic [7:0] OFS_READBACK_B = 8'h2C;
  localparam logic [7:0] OFS_ANGLE = 8'h30;
  // ==========================================================
  // field positions and reset values
  localparam int CTRL_BYPASS = 0;
  localparam int CTRL_ORDER = 1;
  localparam int CTRL_SIGN = 2;
  localparam int CTRL_THRESH_EN = 3;
  localparam int CTRL_GAIN_SAT = 4;
  localparam int CTRL_OFFS_SAT = 5;
  localparam int TC_HOT_POS = 16;
  localparam int ANGLE_SAT_POS = 16;
  localparam logic [5:0] CTRL_RESET = 6'h30;
  localparam logic [15:0] GAIN_RESET = 16'h0400;
  localparam logic [7:0] ROLLOVER_RESET = 8'h00;
  // ==========================================================
  // datapath constants
  localparam logic [15:0] BYPASS_OFFSET = 16'h8000;
  localparam logic [15:0] ANGLE_MAX = 16'hFFFF;
  localparam logic [15:0] HALF_TURN = 16'h8000;
  localparam int GAIN_FRAC = 10;
  localparam int TC_COLD_FRAC = 3;
  localparam int TC_HOT_FRAC = 4;
  localparam int CORDIC_STEPS = 16;

  typedef struct packed {
    logic offs_sat_en;
    logic gain_sat_en;
    logic thresh_en;
    logic sign;
    logic order;
    logic bypass;
  } ctrl_t;

  typedef struct packed {
    logic signed [11:0] hot;
    logic signed [11:0] cold;
  } tempco_t;
endpackage : angle_path_pkg
`default_nettype wire

/* File: hyst_filter.sv */
// hysteresis filter for one channel
`default_nettype none
module hyst_filter
  import angle_path_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic valid_i,
  input wire logic signed [W-1:0] din_i,
  input wire logic [9:0] width_i,
  output logic signed [W-1:0] dout_o,
  output logic valid_o
);
  logic started;
  logic dir_known;
  logic dir_up;
  logic signed [W+1:0] dx;
  logic signed [W+1:0] hx;
  logic signed [W+1:0] wx;

  assign dx = {{2{din_i[W-1]}}, din_i};
  assign hx = {{2{dout_o[W-1]}}, dout_o};
  assign wx = {{(W-8){1'b0}}, width_i};

  // output is the window head; it moves only when input leads or escapes
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      started <= 1'b0;
      dir_known <= 1'b0;
      dir_up <= 1'b0;
      dout_o <= '0;
    end
    else if (ce_i && valid_i)
    begin
      if (width_i == 10'h000)
      begin
        dout_o <= din_i;
        started <= 1'b1;
      end
      else if (!started)
      begin
        dout_o <= din_i;
        started <= 1'b1;
      end
      else if (!dir_known)
      begin
        if (dx != hx)
        begin
          dir_known <= 1'b1;
          dir_up <= dx > hx;
          dout_o <= din_i;
        end
      end
      else if (dir_up)
      begin
        if (dx > hx)
          dout_o <= din_i;
        else if (dx < hx - wx)
        begin
          dir_up <= 1'b0;
          dout_o <= din_i;
        end
        else
          dout_o <= dout_o;
      end
      else
      begin
        if (dx < hx)
          dout_o <= din_i;
        else if (dx > hx + wx)
        begin
          dir_up <= 1'b1;
          dout_o <= din_i;
        end
        else
          dout_o <= dout_o;
      end
    end
  end

  // output strobe trails the input strobe by one cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      valid_o <= 1'b0;
    else if (ce_i)
      valid_o <= valid_i;
  end
endmodule : hyst_filter
`default_nettype wire

/* File: atan2_cordic.sv */
// iterative vectoring-mode arctangent, angle in 2^16 per turn
`default_nettype none
module atan2_cordic
  import angle_path_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic signed [15:0] sin_i,
  input wire logic signed [15:0] cos_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] angle_o
);
  logic signed [19:0] x;
  logic signed [19:0] y;
  logic [4:0] step;

  function automatic logic [15:0] atan_step(input logic [4:0] i);
    case (i)
      5'd0: atan_step = 16'h2000;
      5'd1: atan_step = 16'h12E4;
      5'd2: atan_step = 16'h09FB;
      5'd3: atan_step = 16'h0511;
      5'd4: atan_step = 16'h028B;
      5'd5: atan_step = 16'h0146;
      5'd6: atan_step = 16'h00A3;
      5'd7: atan_step = 16'h0051;
      5'd8: atan_step = 16'h0029;
      5'd9: atan_step = 16'h0014;
      5'd10: atan_step = 16'h000A;
      5'd11: atan_step = 16'h0005;
      5'd12: atan_step = 16'h0003;
      5'd13: atan_step = 16'h0001;
      5'd14: atan_step = 16'h0001;
      default: atan_step = 16'h0000;
    endcase
  endfunction : atan_step

  // left half plane is folded by a half turn first, so steps converge
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      x <= '0;
      y <= '0;
      angle_o <= '0;
      step <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (start_i && !busy_o)
      begin
        busy_o <= 1'b1;
        step <= '0;
        x <= cos_i[15] ? -20'(cos_i) : 20'(cos_i);
        y <= cos_i[15] ? -20'(sin_i) : 20'(sin_i);
        angle_o <= cos_i[15] ? HALF_TURN : 16'h0000;
      end
      else if (busy_o)
      begin
        if (y > 0)
        begin
          x <= x + (y >>> step);
          y <= y - (x >>> step);
          angle_o <= angle_o + atan_step(step);
        end
        else
        begin
          x <= x - (y >>> step);
          y <= y + (x >>> step);
          angle_o <= angle_o - atan_step(step);
        end
        step <= step + 5'd1;
        if (step == 5'(CORDIC_STEPS - 1))
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule : atan2_cordic
`default_nettype wire

/* File: angle_signal_path.sv */
// angle signal path: tempco, hysteresis, atan2, offsets, gain
//
// Overview of operation
// - offset tempco ranges, cold 1/8, hot 1/16
// - zero window width passes input through
// - leading input moves output without delay
// - reversal freezes output inside the window
// - opposite exit flips head and direction
// - first change after reset sets direction
// - window width 0 to 1023 per channel
// - hysteresis outputs readable as 16 bits
// - atan2 with selectable sine/cosine order
// - bypass passes channel plus 32768
// - angle equals atan2(sine, cosine)
// - sign bit gives 360 minus angle
// - pre-gain offset added, always wraps
// - pre-gain offset 15 bits of 360/2^15
// - threshold check raises flag, no clamp
// - gain 6.10 format, zero gives zero
// - no gain saturation means modulo 360
// - saturate to max, zero past rollover
// - rollover 8 bits of 1.40625 degrees
// - default gain saturation on, rollover zero
// - post offset wraps or clamps
// - post offset signed, 720/2^16 steps
// - default post offset saturation on
`default_nettype none
module angle_signal_path
  import angle_path_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // trimmed channel samples
  input wire logic sample_valid_i,
  input wire logic signed [15:0] chan_a_i,
  input wire logic signed [15:0] chan_b_i,
  input wire logic signed [8:0] temp_delta_i,
  // processed angle to linearization
  output logic [15:0] angle_o,
  output logic angle_valid_o,
  output logic sat_flag_o,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  // ==========================================================
  // configuration registers
  ctrl_t ctrl;
  logic [14:0] pre_offs;
  logic [7:0] thresh_low;
  logic [7:0] thresh_high;
  logic [15:0] gain;
  logic [7:0] rollover;
  logic signed [15:0] post_offs;
  logic [9:0] hyst_width [2];
  tempco_t tempco [2];

  logic setup;
  logic wr_en;
  logic mapped;
  logic read_only;
  logic [31:0] next_prdata;

  // ==========================================================
  // datapath signals
  logic signed [15:0] chan_in [2];
  logic signed [15:0] chan_tc [2];
  logic signed [15:0] chan_hy [2];
  logic tc_valid;
  logic [1:0] hy_valid;
  logic signed [15:0] sin_arg;
  logic signed [15:0] cos_arg;
  logic cordic_busy;
  logic cordic_done;
  logic [15:0] cordic_angle;
  logic a0_valid;
  logic [15:0] a0;
  logic [15:0] a1;
  logic [15:0] a2;
  logic thresh_hit;
  logic [31:0] product;
  logic [21:0] gained;
  logic [15:0] a3;
  logic gain_clamped;
  logic signed [17:0] post_sum;
  logic [15:0] a4;

  assign chan_in[0] = chan_a_i;
  assign chan_in[1] = chan_b_i;

  // ==========================================================
  // apb decode
  // zero-wait slave; ce low stretches the access phase
  assign setup = psel_i && !penable_i;
  assign pready_o = ce_i;
  assign wr_en = psel_i && penable_i && pwrite_i && ce_i && mapped && !read_only;

  always_comb
  begin
    mapped = 1'b1;
    read_only = 1'b0;
    next_prdata = 32'h0000_0000;
    case (paddr_i)
      OFS_CTRL: next_prdata = {26'h0, ctrl};
      OFS_PRE_OFFS: next_prdata = {17'h0, pre_offs};
      OFS_THRESH: next_prdata = {16'h0, thresh_high, thresh_low};
      OFS_GAIN: next_prdata = {16'h0, gain};
      OFS_ROLLOVER: next_prdata = {24'h0, rollover};
      OFS_POST_OFFS: next_prdata = {16'h0, post_offs};
      OFS_HYST_A: next_prdata = {22'h0, hyst_width[0]};
      OFS_HYST_B: next_prdata = {22'h0, hyst_width[1]};
      OFS_TC_A: next_prdata = {4'h0, tempco[0].hot, 4'h0, tempco[0].cold};
      OFS_TC_B: next_prdata = {4'h0, tempco[1].hot, 4'h0, tempco[1].cold};
      OFS_READBACK_A:
      begin
        next_prdata = {16'h0, chan_hy[0]};
        read_only = 1'b1;
      end
      OFS_READBACK_B:
      begin
        next_prdata = {16'h0, chan_hy[1]};
        read_only = 1'b1;
      end
      OFS_ANGLE:
      begin
        next_prdata = {15'h0, sat_flag_o, angle_o};
        read_only = 1'b1;
      end
      default: mapped = 1'b0;
    endcase
  end

  // read data and error latched in the setup cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (ce_i && setup)
    begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
      pslverr_o <= !mapped || (pwrite_i && read_only);
    end
  end

  // ==========================================================
  // register writes
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      ctrl <= ctrl_t'(CTRL_RESET);
      pre_offs <= '0;
      thresh_low <= '0;
      thresh_high <= '0;
      gain <= GAIN_RESET;
      rollover <= ROLLOVER_RESET;
      post_offs <= '0;
    end
    else if (wr_en)
    begin
      case (paddr_i)
        OFS_CTRL: ctrl <= ctrl_t'(pwdata_i[5:0]);
        OFS_PRE_OFFS: pre_offs <= pwdata_i[14:0];
        OFS_THRESH:
        begin
          thresh_low <= pwdata_i[7:0];
          thresh_high <= pwdata_i[15:8];
        end
        OFS_GAIN: gain <= pwdata_i[15:0];
        OFS_ROLLOVER: rollover <= pwdata_i[7:0];
        OFS_POST_OFFS: post_offs <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // per-channel stages: tempco, hysteresis
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      logic signed [11:0] tc_coef;
      logic signed [20:0] tc_prod;
      logic signed [20:0] tc_shift;
      logic signed [20:0] tc_sum;
      logic [7:0] ofs_width;
      logic [7:0] ofs_tc;

      assign ofs_width = (ch == 0) ? OFS_HYST_A : OFS_HYST_B;
      assign ofs_tc = (ch == 0) ? OFS_TC_A : OFS_TC_B;

      // per-channel width and tempco settings
      always_ff @(posedge ref_clk_i)
      begin
        if (!rst_b_i)
        begin
          hyst_width[ch] <= '0;
          tempco[ch] <= '0;
        end
        else if (wr_en && paddr_i == ofs_width)
          hyst_width[ch] <= pwdata_i[9:0];
        else if (wr_en && paddr_i == ofs_tc)
        begin
          tempco[ch].cold <= pwdata_i[11:0];
          tempco[ch].hot <= pwdata_i[TC_HOT_POS+11:TC_HOT_POS];
        end
      end

      // cold coefficient below 25 C, hot at or above
      assign tc_coef = temp_delta_i[8] ? tempco[ch].cold : tempco[ch].hot;
      assign tc_prod = 21'(tc_coef * temp_delta_i);
      assign tc_shift = temp_delta_i[8] ? (tc_prod >>> TC_COLD_FRAC) : (tc_prod >>> TC_HOT_FRAC);
      assign tc_sum = 21'(chan_in[ch]) + tc_shift;

      // saturate to 16 bits rather than wrap a channel's sign
      always_ff @(posedge ref_clk_i)
      begin
        if (!rst_b_i)
          chan_tc[ch] <= '0;
        else if (ce_i && sample_valid_i)
        begin
          if (tc_sum > 21'sd32767)
            chan_tc[ch] <= 16'sh7FFF;
          else if (tc_sum < -21'sd32768)
            chan_tc[ch] <= 16'sh8000;
          else
            chan_tc[ch] <= tc_sum[15:0];
        end
      end

      hyst_filter #(.W(16)) u_hyst (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .valid_i(tc_valid),
        .din_i(chan_tc[ch]),
        .width_i(hyst_width[ch]),
        .dout_o(chan_hy[ch]),
        .valid_o(hy_valid[ch])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      tc_valid <= 1'b0;
    else if (ce_i)
      tc_valid <= sample_valid_i;
  end

  // ==========================================================
  // angle source: atan2 or one-channel bypass
  assign sin_arg = ctrl.order ? chan_hy[1] : chan_hy[0];
  assign cos_arg = ctrl.order ? chan_hy[0] : chan_hy[1];

  // a sample arriving while busy is dropped; samples are far slower
  atan2_cordic u_cordic (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .start_i(hy_valid[0] && !ctrl.bypass && !cordic_busy),
    .sin_i(sin_arg),
    .cos_i(cos_arg),
    .busy_o(cordic_busy),
    .done_o(cordic_done),
    .angle_o(cordic_angle)
  );

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      a0 <= '0;
      a0_valid <= 1'b0;
    end
    else if (ce_i)
    begin
      a0_valid <= 1'b0;
      if (ctrl.bypass && hy_valid[0])
      begin
        a0 <= sin_arg + BYPASS_OFFSET;
        a0_valid <= 1'b1;
      end
      else if (!ctrl.bypass && cordic_done)
      begin
        a0 <= cordic_angle;
        a0_valid <= 1'b1;
      end
    end
  end

  // ==========================================================
  // sign, pre-gain offset, threshold
  assign a1 = ctrl.sign ? 16'(16'h0000 - a0) : a0;
  assign a2 = a1 + {pre_offs, 1'b0};
  assign thresh_hit = ctrl.thresh_en &&
    (a2 < {thresh_low, 8'h00} || a2 > {thresh_high, 8'h00});

  // ==========================================================
  // gain with saturation or rollover
  assign product = a2 * gain;
  assign gained = product[GAIN_FRAC+21:GAIN_FRAC];

  always_comb
  begin
    gain_clamped = 1'b0;
    if (!ctrl.gain_sat_en)
      a3 = gained[15:0];
    else if (gained[21:16] == 6'h00)
      a3 = gained[15:0];
    else if (a2 <= {rollover, 8'h00})
    begin
      a3 = ANGLE_MAX;
      gain_clamped = 1'b1;
    end
    else
      a3 = 16'h0000;
  end

  // ==========================================================
  // post-gain offset, step is two angle codes
  assign post_sum = {2'b00, a3} + {post_offs[15], post_offs, 1'b0};

  always_comb
  begin
    if (!ctrl.offs_sat_en)
      a4 = post_sum[15:0];
    else if (post_sum < 0)
      a4 = 16'h0000;
    else if (post_sum > 18'sh0FFFF)
      a4 = ANGLE_MAX;
    else
      a4 = post_sum[15:0];
  end

  // output stage registered once per angle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      angle_o <= '0;
      angle_valid_o <= 1'b0;
      sat_flag_o <= 1'b0;
    end
    else if (ce_i)
    begin
      angle_valid_o <= a0_valid;
      if (a0_valid)
      begin
        angle_o <= a4;
        sat_flag_o <= thresh_hit || gain_clamped;
      end
    end
  end
endmodule : angle_signal_path
`default_nettype wire

/* File: angle_path_properties.sv */
// checker: apb answers and angle stream timing of the angle signal path
`default_nettype none
module angle_path_properties
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] angle_o,
  input wire logic angle_valid_o,
  input wire logic sat_flag_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic setup;
  logic rd_setup;

  // ==========================================================
  // phase decode
  // read data is latched at an enabled setup edge, so every setup-based check looks one edge on
  assign setup = psel_i && !penable_i && ce_i;
  assign rd_setup = setup && !pwrite_i;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  // bus answers
  a_ready_tracks_ce:
  assert property (pready_o == ce_i) else $error("pready does not follow ce");
  a_unmapped_err:
  assert property (setup && paddr_i > 8'h30 |=> pslverr_o && prdata_o == 32'h0) else $error("unmapped not refused");
  a_ro_write_err:
  assert property (setup && pwrite_i && paddr_i inside {8'h28, 8'h2C, 8'h30} |=> pslverr_o)
    else $error("read-only write not refused");
  a_prdata_holds:
  assert property (!setup |=> $stable(prdata_o) && $stable(pslverr_o)) else $error("read data moved");
  a_readback_width:
  assert property (rd_setup && paddr_i inside {8'h28, 8'h2C} |=> !pslverr_o && prdata_o[31:16] == 16'h0)
    else $error("readback not 16 bits");
  a_hyst_field:
  assert property (rd_setup && paddr_i inside {8'h18, 8'h1C} |=> prdata_o[31:10] == 22'h0)
    else $error("width field too wide");
  a_pre_offs_field:
  assert property (rd_setup && paddr_i == 8'h04 |=> prdata_o[31:15] == 17'h0) else $error("pre offset too wide");
  a_rollover_field:
  assert property (rd_setup && paddr_i == 8'h10 |=> prdata_o[31:8] == 24'h0) else $error("rollover too wide");

  // ==========================================================
  // angle stream
  a_valid_has_cause:
  assert property (angle_valid_o |-> $past(sample_valid_i, 4) || $past(sample_valid_i, 21))
    else $error("angle valid without sample");
  a_angle_holds:
  assert property (!angle_valid_o |-> $stable(angle_o)) else $error("angle moved without valid");
  a_sat_holds:
  assert property (!angle_valid_o |-> $stable(sat_flag_o)) else $error("sat flag moved without valid");
endmodule : angle_path_properties
`default_nettype wire

/* File: chan_stream_model.sv */
// partner model: upstream sample source and downstream angle sink
`default_nettype none
module chan_stream_model
(
  input wire logic ref_clk_i,
  input wire logic [15:0] angle_i,
  input wire logic angle_valid_i,
  input wire logic sat_flag_i,
  output logic sample_valid_o,
  output logic signed [15:0] chan_a_o,
  output logic signed [15:0] chan_b_o,
  output logic signed [8:0] temp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle lines carry junk, never the last sample
  initial
  begin
    sample_valid_o = 1'b0;
    chan_a_o = 16'h5A5A;
    chan_b_o = 16'hA5A5;
    temp_o = 9'h155;
  end

  // ==========================================================
  // one sample in, one angle out, bounded wait
  task send(input logic [15:0] a, input logic [15:0] b, input logic [8:0] t,
            output logic [15:0] ang, output logic sat, output logic ok);
    int n;
    @(posedge ref_clk_i);
    sample_valid_o <= 1'b1;
    chan_a_o <= a;
    chan_b_o <= b;
    temp_o <= t;
    @(posedge ref_clk_i);
    sample_valid_o <= 1'b0;
    chan_a_o <= ~a;
    chan_b_o <= ~b;
    temp_o <= ~t;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 40)
    begin
      @(posedge ref_clk_i);
      ok = (angle_valid_i === 1'b1);
      n++;
    end
    ang = angle_i;
    sat = sat_flag_i;
  endtask : send
endmodule : chan_stream_model
`default_nettype wire

/* File: testbench.sv */
// testbench: register access and angle path scenarios
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench
  import angle_path_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sv;
  logic signed [15:0] ca;
  logic signed [15:0] cb;
  logic signed [8:0] td;
  logic [15:0] angle;
  logic av;
  logic sat;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [15:0] hin [7] = '{16'h64, 16'h82, 16'h78, 16'h8C, 16'h7D, 16'h64, 16'h6E};
  logic [15:0] hout [7] = '{16'h64, 16'h82, 16'h82, 16'h8C, 16'h8C, 16'h64, 16'h64};
  logic [15:0] ta [6] = '{16'h0, 16'h2710, 16'h0, 16'hD8F0, 16'h2710, 16'h0};
  logic [15:0] tb [6] = '{16'h2710, 16'h0, 16'hD8F0, 16'h0, 16'h0, 16'h2710};
  logic [15:0] te [6] = '{16'h0, 16'h4000, 16'h8000, 16'hC000, 16'h0, 16'h4000};

  angle_signal_path u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .sample_valid_i(sv),
    .chan_a_i(ca), .chan_b_i(cb), .temp_delta_i(td), .angle_o(angle), .angle_valid_o(av), .sat_flag_o(sat),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  chan_stream_model u_src (.ref_clk_i(ref_clk_i), .angle_i(angle), .angle_valid_i(av), .sat_flag_i(sat),
    .sample_valid_o(sv), .chan_a_o(ca), .chan_b_o(cb), .temp_o(td));

  // ==========================================================
  // clock and hang limit
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ==========================================================
  // bus and stream tasks
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1)
      @(posedge ref_clk_i);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    `CHK("write error", 1'b0, e)
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("read data", ex, r)
  endtask : rd
  // sat of x means the flag is not judged
  task ang(input logic [15:0] a, input logic [8:0] t, input logic [15:0] ex, input logic s);
    logic [15:0] g;
    logic gs;
    logic ok;
    u_src.send(a, 16'h0000 - a, t, g, gs, ok);
    `CHK("angle valid", 1'b1, ok)
    `CHK("angle", ex, g)
    if (s !== 1'bx)
      `CHK("sat flag", s, gs)
  endtask : ang
  // arctangent is approximate, so a few codes of slack
  task near(input logic [15:0] a, input logic [15:0] b, input logic [15:0] ex);
    logic [15:0] g;
    logic gs;
    logic ok;
    logic signed [15:0] d;
    u_src.send(a, b, 9'h000, g, gs, ok);
    d = g - ex;
    total_checks++;
    if (ok !== 1'b1 || ((d < -16'sh0008) || (d > 16'sh0008)) !== 1'b0)
    begin
      n_mismatch++;
      $display("[ERR] atan2 exp %h got %h", ex, g);
    end
  endtask : near

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] r;
    logic e;
    logic f;
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(OFS_CTRL, 32'h30);
    rd(OFS_ROLLOVER, 32'h0);
    rd(OFS_GAIN, 32'h400);
    apb(1'b0, 8'h40, 32'h0, r, e);
    `CHK("unmapped error", 1'b1, e)
    apb(1'b1, OFS_READBACK_A, 32'hFFFF, r, e);
    `CHK("read-only error", 1'b1, e)
    wr(OFS_CTRL, 32'h01);
    wr(OFS_HYST_A, 32'hFFFFFFFF);
    rd(OFS_HYST_A, 32'h3FF);
    wr(OFS_HYST_A, 32'h14);
    for (int i = 0; i < 7; i++)
    begin
      ang(hin[i], 9'h000, hout[i] + 16'h8000, 1'bx);
      rd(OFS_READBACK_A, {16'h0, hout[i]});
      rd(OFS_READBACK_B, {16'h0, 16'h0000 - hin[i]});
    end
    wr(OFS_HYST_A, 32'h0);
    ang(16'h8000, 9'h000, 16'h0000, 1'bx);
    ang(16'h0000, 9'h000, 16'h8000, 1'bx);
    ang(16'h7FFF, 9'h000, 16'hFFFF, 1'bx);
    wr(OFS_CTRL, 32'h03);
    ang(16'hF000, 9'h000, 16'h9000, 1'bx);
    wr(OFS_CTRL, 32'h05);
    ang(16'h1000, 9'h000, 16'h7000, 1'bx);
    ang(16'h8000, 9'h000, 16'h0000, 1'bx);
    wr(OFS_CTRL, 32'h01);
    wr(OFS_PRE_OFFS, 32'hFFFFFFFF);
    rd(OFS_PRE_OFFS, 32'h7FFF);
    wr(OFS_PRE_OFFS, 32'h4000);
    ang(16'h1000, 9'h000, 16'h1000, 1'bx);
    wr(OFS_PRE_OFFS, 32'h0);
    wr(OFS_CTRL, 32'h09);
    wr(OFS_THRESH, 32'h8020);
    ang(16'h9000, 9'h000, 16'h1000, 1'b1);
    ang(16'hC000, 9'h000, 16'h4000, 1'b0);
    ang(16'h1000, 9'h000, 16'h9000, 1'b1);
    wr(OFS_CTRL, 32'h01);
    wr(OFS_GAIN, 32'h800);
    ang(16'h2000, 9'h000, 16'h4000, 1'b0);
    wr(OFS_GAIN, 32'h0);
    ang(16'h2000, 9'h000, 16'h0000, 1'b0);
    wr(OFS_CTRL, 32'h11);
    wr(OFS_GAIN, 32'h800);
    wr(OFS_ROLLOVER, 32'hC0);
    ang(16'h0000, 9'h000, 16'hFFFF, 1'b1);
    ang(16'hFFFF, 9'h000, 16'hFFFE, 1'b0);
    ang(16'h5000, 9'h000, 16'h0000, 1'bx);
    ang(16'hC000, 9'h000, 16'h8000, 1'b0);
    wr(OFS_GAIN, 32'h400);
    wr(OFS_CTRL, 32'h21);
    wr(OFS_POST_OFFS, 32'hF800);
    ang(16'h8800, 9'h000, 16'h0000, 1'bx);
    wr(OFS_CTRL, 32'h01);
    ang(16'h8800, 9'h000, 16'hF800, 1'bx);
    wr(OFS_POST_OFFS, 32'h7000);
    ang(16'h4000, 9'h000, 16'hA000, 1'bx);
    wr(OFS_CTRL, 32'h21);
    ang(16'h4000, 9'h000, 16'hFFFF, 1'bx);
    wr(OFS_CTRL, 32'h01);
    wr(OFS_POST_OFFS, 32'h0);
    wr(OFS_TC_A, 32'h0800_0800);
    rd(OFS_TC_A, 32'h0800_0800);
    ang(16'h1000, 9'h1FF, 16'h9100, 1'bx);
    ang(16'h1000, 9'h001, 16'h8F80, 1'bx);
    wr(OFS_TC_A, 32'h0);
    // clock enable low: a sample is ignored and the bus is held off
    ce_i <= 1'b0;
    u_src.send(16'h1000, 16'h0000, 9'h000, r[15:0], e, f);
    `CHK("frozen valid", 1'b0, f)
    `CHK("frozen ready", 1'b0, pready)
    ce_i <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      if (i == 0 || i == 4)
        wr(OFS_CTRL, (i == 0) ? 32'h00 : 32'h02);
      near(ta[i], tb[i], te[i]);
    end
    give_verdict();
  end
endmodule : testbench

bind angle_signal_path angle_path_properties u_props (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .sample_valid_i(sample_valid_i), .angle_o(angle_o), .angle_valid_o(angle_valid_o), .sat_flag_o(sat_flag_o),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o));
`default_nettype wire
